// [rtl/pwe_pkg.sv]
package pwe_pkg;
	// Register byte offsets on the AXI4-Lite bus
	localparam logic [7:0] PWE_OFF_PINS = 8'h00;
	localparam logic [7:0] PWE_OFF_DRVDIS = 8'h04;
	localparam logic [7:0] PWE_OFF_LATCH = 8'h08;
	localparam logic [7:0] PWE_OFF_ANSEL = 8'h0C;
	localparam logic [7:0] PWE_OFF_RISE = 8'h10;
	localparam logic [7:0] PWE_OFF_FALL = 8'h14;
	localparam logic [7:0] PWE_OFF_FLAGS = 8'h18;
	localparam logic [7:0] PWE_OFF_ICTL = 8'h1C;
	// Widths
	localparam int PWE_NPIN = 4;
	localparam int PWE_NDRV = 3;
	// Reset values
	localparam logic [2:0] PWE_DRVDIS_RST = 3'h7;
	localparam logic [2:0] PWE_ANSEL_RST = 3'h7;
	localparam logic [2:0] PWE_LATCH_RST = 3'h0;
	localparam logic [3:0] PWE_EDGE_RST = 4'h0;
	// Interrupt control field positions and driver-disable bit three position
	localparam int PWE_ICTL_SUM = 0;
	localparam int PWE_ICTL_IE = 3;
	localparam int PWE_DRVDIS_B3 = 3;
	// AXI responses
	localparam logic [1:0] PWE_RESP_OKAY = 2'h0;
	localparam logic [1:0] PWE_RESP_SLVERR = 2'h2;

	// Write request gathered from the bus
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} pwe_wreq_t;
endpackage

// [rtl/pwe_port.sv]
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - Port read returns four live pin levels
// - Port write goes to output latch
// - Latch read returns stored latch bits
// - Driver-disable bits, reset to one
// - Driver-disable bit three reads one
// - Analog select disables digital input buffer
// - Analog select leaves pull-ups unchanged
// - Edge flags set regardless of master enable
// - Rising detector gated by rising enable
// - Falling detector gated by falling enable
// - Both enables detect both edges
// - Enabled edge sets sticky flag, requests interrupt if master enable set
// - Summary flag is OR of flags
// - Set wins over clearing write
// - Enabled edge wakes from sleep if master enable set
// - Flags updated before wake completes
module pwe_port #(
	parameter int NPIN = pwe_pkg::PWE_NPIN
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// AXI4-Lite write address
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Pins
	input wire logic [3:0] PIN_IN,
	output logic [2:0] PIN_OUT,
	output logic [2:0] PIN_OE,
	output logic [2:0] PIN_DIG_IN_EN,
	// Core interface
	input wire logic SLEEP,
	output logic CHANGE_IRQ,
	output logic WAKE
);
	import pwe_pkg::*;

	logic [2:0] latch_r;
	logic [2:0] drvdis_r;
	logic [2:0] ansel_r;
	logic [NPIN-1:0] rise_en_r;
	logic [NPIN-1:0] fall_en_r;
	logic [NPIN-1:0] flags_r;
	logic [NPIN-1:0] flags_nxt;
	logic irq_en_r;
	logic [NPIN-1:0] samp_r;
	logic [NPIN-1:0] prev_r;
	logic [NPIN-1:0] edge_hit;
	logic aw_held_r;
	logic w_held_r;
	pwe_wreq_t wreq_r;
	logic do_write;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_ok;

	// Write address and data accepted in either order
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wreq_r <= '0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held_r <= 1'b1;
				wreq_r.addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held_r <= 1'b1;
				wreq_r.data <= S_AXI_WDATA;
				wreq_r.strb <= S_AXI_WSTRB;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// Each ready when its own channel holds nothing and no response pending
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
		end else begin
			S_AXI_AWREADY <= !aw_held_r && !S_AXI_BVALID &&
				!(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY <= !w_held_r && !S_AXI_BVALID &&
				!(S_AXI_WVALID && S_AXI_WREADY);
		end
	end

	assign do_write = aw_held_r && w_held_r && !S_AXI_BVALID;

	// Decode of writable addresses
	always_comb begin
		unique case (wreq_r.addr)
			PWE_OFF_PINS, PWE_OFF_DRVDIS, PWE_OFF_LATCH, PWE_OFF_ANSEL,
			PWE_OFF_RISE, PWE_OFF_FALL, PWE_OFF_FLAGS,
			PWE_OFF_ICTL: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Write response
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= PWE_RESP_OKAY;
		end else if (do_write) begin
			S_AXI_BVALID <= 1'b1;
			S_AXI_BRESP <= wr_ok ? PWE_RESP_OKAY : PWE_RESP_SLVERR;
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// Output latch, reached through both port and latch offsets
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			latch_r <= PWE_LATCH_RST;
		end else if (do_write && wreq_r.strb[0] &&
			(wreq_r.addr == PWE_OFF_PINS ||
			wreq_r.addr == PWE_OFF_LATCH)) begin
			latch_r <= wreq_r.data[2:0];
		end
	end

	// Driver disable and analog select
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			drvdis_r <= PWE_DRVDIS_RST;
			ansel_r <= PWE_ANSEL_RST;
		end else if (do_write && wreq_r.strb[0]) begin
			if (wreq_r.addr == PWE_OFF_DRVDIS)
				drvdis_r <= wreq_r.data[2:0];
			if (wreq_r.addr == PWE_OFF_ANSEL)
				ansel_r <= wreq_r.data[2:0];
		end
	end

	// Edge enables and master enable
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rise_en_r <= PWE_EDGE_RST;
			fall_en_r <= PWE_EDGE_RST;
			irq_en_r <= 1'b0;
		end else if (do_write && wreq_r.strb[0]) begin
			if (wreq_r.addr == PWE_OFF_RISE)
				rise_en_r <= wreq_r.data[NPIN-1:0];
			if (wreq_r.addr == PWE_OFF_FALL)
				fall_en_r <= wreq_r.data[NPIN-1:0];
			if (wreq_r.addr == PWE_OFF_ICTL)
				irq_en_r <= wreq_r.data[PWE_ICTL_IE];
		end
	end

	// Pin samples: current and previous, on the core clock
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			samp_r <= '0;
			prev_r <= '0;
		end else begin
			samp_r <= PIN_IN;
			prev_r <= samp_r;
		end
	end

	// Per-pin detectors on the sampled levels, analog select ignored
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_det
			assign edge_hit[gi] =
				(rise_en_r[gi] && samp_r[gi] && !prev_r[gi]) ||
				(fall_en_r[gi] && !samp_r[gi] && prev_r[gi]);
		end
	endgenerate

	// Sticky flags; a new edge overrides the clearing write
	always_comb begin
		flags_nxt = flags_r;
		if (do_write && wreq_r.strb[0] && wreq_r.addr == PWE_OFF_FLAGS)
			flags_nxt = flags_r & wreq_r.data[NPIN-1:0];
		flags_nxt = flags_nxt | edge_hit;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N)
			flags_r <= PWE_EDGE_RST;
		else
			flags_r <= flags_nxt;
	end

	// Read mux
	always_comb begin
		rd_val = '0;
		rd_ok = 1'b1;
		unique case (S_AXI_ARADDR)
			PWE_OFF_PINS: rd_val[NPIN-1:0] = samp_r;
			PWE_OFF_DRVDIS: begin
				rd_val[2:0] = drvdis_r;
				rd_val[PWE_DRVDIS_B3] = 1'b1;
			end
			PWE_OFF_LATCH: rd_val[2:0] = latch_r;
			PWE_OFF_ANSEL: rd_val[2:0] = ansel_r;
			PWE_OFF_RISE: rd_val[NPIN-1:0] = rise_en_r;
			PWE_OFF_FALL: rd_val[NPIN-1:0] = fall_en_r;
			PWE_OFF_FLAGS: rd_val[NPIN-1:0] = flags_r;
			PWE_OFF_ICTL: begin
				rd_val[PWE_ICTL_IE] = irq_en_r;
				rd_val[PWE_ICTL_SUM] = |flags_r;
			end
			default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: one read in flight
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= '0;
			S_AXI_RRESP <= PWE_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY &&
				S_AXI_ARVALID;
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_val;
				S_AXI_RRESP <= rd_ok ? PWE_RESP_OKAY : PWE_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// Pin drive: latch out, enable when driver not disabled
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			PIN_OUT <= PWE_LATCH_RST;
			PIN_OE <= '0;
			PIN_DIG_IN_EN <= '0;
		end else begin
			PIN_OUT <= latch_r;
			PIN_OE <= ~drvdis_r;
			// Only the input buffer is affected, pull-ups untouched
			PIN_DIG_IN_EN <= ~ansel_r;
		end
	end

	// Interrupt request gated by master enable, wake by master enable and SLEEP
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			CHANGE_IRQ <= 1'b0;
			WAKE <= 1'b0;
		end else begin
			CHANGE_IRQ <= irq_en_r && |flags_nxt;
			// Flags are set at the same edge as wake, or earlier
			WAKE <= SLEEP && irq_en_r && |flags_nxt;
		end
	end
endmodule

// [verif/pwe_port_asserts.sv]
`timescale 1ns/1ps
module pwe_port_asserts (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// Bus answers
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// Pins and core
	input wire logic [2:0] PIN_OE,
	input wire logic [2:0] PIN_DIG_IN_EN,
	input wire logic SLEEP,
	input wire logic WAKE,
	input wire logic CHANGE_IRQ
);
	import pwe_pkg::*;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	property p_rlat;
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read late");
	property p_rst;
		$rose(RST_N) |-> !(|{PIN_OE, PIN_DIG_IN_EN, WAKE, CHANGE_IRQ});
	endproperty
	a_rst: assert property (p_rst) else $error("reset outputs");
	property p_wake;
		WAKE |-> $past(SLEEP);
	endproperty
	a_wake: assert property (p_wake) else $error("wake awake");
	property p_wirq;
		WAKE |-> CHANGE_IRQ;
	endproperty
	a_wirq: assert property (p_wirq) else $error("wake no irq");
	property p_zero;
		S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h000_0000;
	endproperty
	a_zero: assert property (p_zero) else $error("upper bits");
	property p_err;
		S_AXI_RVALID && S_AXI_RRESP != PWE_RESP_OKAY
			|-> S_AXI_RDATA == 32'h0 && S_AXI_RRESP == PWE_RESP_SLVERR;
	endproperty
	a_err: assert property (p_err) else $error("bad error read");
	property p_rdone;
		S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read twice");
	property p_bdone;
		S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write twice");
	c_wake: cover property (WAKE);
	c_irq: cover property (CHANGE_IRQ && !SLEEP);
	c_err: cover property (S_AXI_RVALID && S_AXI_RRESP != PWE_RESP_OKAY);
endmodule
bind pwe_port pwe_port_asserts chk_u (.*);

// [verif/pwe_pins.sv]
`timescale 1ns/1ps
module pwe_pins (
	// Pad drivers
	input wire logic [2:0] drv,
	input wire logic [2:0] oe,
	// Outside levels
	input wire logic [3:0] ext,
	// Pad levels
	output logic [3:0] lvl
);
	// Driven pad follows its latch, released pad the outside
	assign lvl = {ext[3], (oe & drv) | (~oe & ext[2:0])};
endmodule

// [verif/pwe_port_tb.sv]
`timescale 1ns/1ps
module pwe_port_tb;
	import pwe_pkg::*;
	logic REF_CLK = 1'h0, RST_N = 1'h0, SLEEP = 1'h0;
	logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, r;
	logic [3:0] S_AXI_WSTRB = 4'h0, ext = 4'h0, m;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
	logic S_AXI_ARREADY, S_AXI_RVALID, CHANGE_IRQ, WAKE;
	logic [3:0] PIN_IN;
	logic [2:0] PIN_OUT, PIN_OE, PIN_DIG_IN_EN;
	logic [33:0] q[$];
	int mismatches = 0, samples_checked = 0;
	always #2.5 REF_CLK = ~REF_CLK;
	pwe_port dut_u (.*);
	pwe_pins pins_u (.drv(PIN_OUT), .oe(PIN_OE), .ext(ext), .lvl(PIN_IN));
	task cmp(input logic [33:0] g, input logic [33:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		$display("%0d mismatches, %0d checked", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Read answers against the oldest note
	always @(posedge REF_CLK) begin
		if (S_AXI_RVALID && S_AXI_RREADY)
			cmp({S_AXI_RRESP, S_AXI_RDATA}, q.pop_front());
	end
	// Each channel is released only at the edge where it is taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 1'b0;
		@(posedge REF_CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_WSTRB <= 4'h1;
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		while (!done) begin
			@(posedge REF_CLK);
			if (S_AXI_AWVALID && S_AXI_AWREADY)
				S_AXI_AWVALID <= 1'h0;
			if (S_AXI_WVALID && S_AXI_WREADY)
				S_AXI_WVALID <= 1'h0;
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BREADY <= 1'h0;
				done = 1'b1;
			end
		end
	endtask
	task rd(input logic [7:0] a, input logic [33:0] e);
		logic done;
		done = 1'b0;
		q.push_back(e);
		@(posedge REF_CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		while (!done) begin
			@(posedge REF_CLK);
			if (S_AXI_ARVALID && S_AXI_ARREADY)
				S_AXI_ARVALID <= 1'h0;
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RREADY <= 1'h0;
				done = 1'b1;
			end
		end
	endtask
	task pins(input logic [3:0] v);
		@(posedge REF_CLK);
		ext <= v;
		repeat (6) @(posedge REF_CLK);
	endtask
	// Hang guard
	initial begin
		#200000;
		mismatches++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h0000_5DF7));
		r = $urandom();
		ext <= r[3:0];
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'h1;
		rd(PWE_OFF_DRVDIS, 8'h0F);
		rd(PWE_OFF_LATCH, 8'h00);
		rd(PWE_OFF_ANSEL, 8'h07);
		for (logic [7:0] a = 8'h10; a < 8'h20; a += 8'h04)
			rd(a, 8'h00);
		rd(8'h20, {PWE_RESP_SLVERR, 32'h0});
		cmp(PIN_OE, 3'h0);
		$display("reset test done");
		r = $urandom();
		wr(PWE_OFF_PINS, r);
		wr(PWE_OFF_DRVDIS, 8'h00);
		wr(PWE_OFF_ANSEL, 8'h00);
		rd(PWE_OFF_LATCH, r[2:0]);
		rd(PWE_OFF_PINS, {ext[3], r[2:0]});
		cmp(PIN_OUT, r[2:0]);
		cmp(PIN_DIG_IN_EN, 3'h7);
		wr(PWE_OFF_DRVDIS, 8'h07);
		wr(PWE_OFF_ANSEL, 8'h07);
		$display("port test done");
		pins(4'h0);
		for (int k = 1; k < 4; k++) begin
			wr(PWE_OFF_RISE, {4{k[0]}});
			wr(PWE_OFF_FALL, {4{k[1]}});
			r = $urandom();
			m = r[3:0] | 4'h1;
			pins(m);
			rd(PWE_OFF_FLAGS, m & {4{k[0]}});
			pins(4'h0);
			rd(PWE_OFF_FLAGS, m);
			rd(PWE_OFF_ICTL, 8'h01);
			cmp(CHANGE_IRQ, 1'h0);
			wr(PWE_OFF_FLAGS, 8'h00);
			rd(PWE_OFF_FLAGS, 8'h00);
		end
		$display("edge test done");
		wr(PWE_OFF_ICTL, 8'h08);
		SLEEP <= 1'h1;
		pins(4'hF);
		cmp(CHANGE_IRQ, 1'h1);
		cmp(WAKE, 1'h1);
		rd(PWE_OFF_FLAGS, 8'h0F);
		SLEEP <= 1'h0;
		wr(PWE_OFF_FLAGS, 8'h00);
		rd(PWE_OFF_ICTL, 8'h08);
		cmp(CHANGE_IRQ, 1'h0);
		$display("wake test done");
		give_verdict;
	end
endmodule
